// ### core/adc_power_mode_control.sv
// sequencer, control word, power-down and read pointer of the converter
`include "adc_ctrl_defs.svh"
`default_nettype none
// Contract
// - after reset completion flag high and ready for convert-start
// - after reset mode is bank A, single channel
// - result memory is undefined until a sequence writes it
// - control word with power-down bit set powers down at latching edge; code ignores such a write while a sequence runs
// - in power-down core and reference buffer off, interface still takes writes
// - control word with power-down bit clear wakes, selects mode from low bits
// - results are two's-complement binary
// - control word: top bit power-down, next bank, low two count minus one
// - sample at convert-start rise; ignore further starts until sequence ends
// - flag falls at last conversion end; track/holds return to tracking
// - first read fall gives channel one, sets flag high; read rise advances, wraps; code leaves the flag unchanged on reads in power-down
module adc_power_mode_control #(
   parameter int CHANNELS = 4,
   parameter int WIDTH = 14,
   parameter int CONV_CYCLES = `CONV_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_cs_n,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic i_convert_start_n,
   input wire logic [3:0] i_control_word_bits,
   input wire logic [CHANNELS*WIDTH-1:0] i_sample_bank_a,
   input wire logic [CHANNELS*WIDTH-1:0] i_sample_bank_b,
   output logic [WIDTH-1:0] o_result_bus,
   output logic o_result_oe,
   output logic o_done_n,
   output logic o_power_down,
   output logic o_bank_b,
   output logic o_hold,
   output logic [1:0] o_channel_count
);
   localparam int AW = $clog2(CHANNELS);
   localparam int CW = $clog2(CONV_CYCLES + 1);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [4:0] s1_ff;
   logic [4:0] s2_ff;
   logic [4:0] s3_ff;
   logic [3:0] cw1_ff;
   logic [3:0] cw2_ff;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_ff <= 5'h1f;
         s2_ff <= 5'h1f;
         s3_ff <= 5'h1f;
         cw1_ff <= 4'h0;
         cw2_ff <= 4'h0;
      end else begin
         s1_ff <= {i_cs_n, i_wr_n, i_rd_n, i_convert_start_n, 1'b1};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         cw1_ff <= i_control_word_bits;
         cw2_ff <= cw1_ff;
      end
   end

   // strobe decoding on synchronised levels
   wire cs_n = s2_ff[4];
   wire wr_n = s2_ff[3];
   wire rd_n = s2_ff[2];
   wire cv_n = s2_ff[1];
   wire cs_n_d = s3_ff[4];
   wire wr_n_d = s3_ff[3];
   wire rd_n_d = s3_ff[2];
   wire cv_n_d = s3_ff[1];
   wire wr_act = !cs_n && !wr_n;
   wire wr_act_d = !cs_n_d && !wr_n_d;
   wire wr_latch = wr_act_d && !wr_act;   // rise of write or chip select
   wire rd_act = !cs_n && !rd_n;
   wire rd_act_d = !cs_n_d && !rd_n_d;
   wire rd_fall = rd_act && !rd_act_d;
   wire rd_rise = rd_act_d && !rd_act;
   wire cv_rise = cv_n && !cv_n_d;

   // ------------------------------------------------------------
   // control word and sequencer
   // ------------------------------------------------------------
   adc_ctrl_pkg::seq_state_e state_ff;
   adc_ctrl_pkg::seq_state_e nxt_state;
   logic [3:0] cw_ff;
   logic [3:0] cw_wr_ff;
   logic [CW-1:0] cyc_ff;
   logic [AW-1:0] chan_ff;
   logic [AW-1:0] rptr_ff;
   logic done_n_ff;
   logic hold_ff;
   logic oe_ff;
   logic [CHANNELS*WIDTH-1:0] held_ff;

   wire cw_pd = cw_wr_ff[`CW_PD_BIT];
   wire [AW-1:0] last_chan = AW'(cw_ff[`CW_CNT_MSB:`CW_CNT_LSB]);
   wire conv_end = (state_ff == adc_ctrl_pkg::ST_CONVERT) && (cyc_ff == CW'(CONV_CYCLES - 1));
   wire last_end = conv_end && (chan_ff == last_chan);
   wire [WIDTH-1:0] cur_sample = held_ff[chan_ff*WIDTH +: WIDTH];

   // state transitions
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         adc_ctrl_pkg::ST_IDLE: begin
            if (wr_latch && cw1_hold_pd()) begin
               nxt_state = adc_ctrl_pkg::ST_POWER_DOWN;
            end else if (cv_rise) begin
               nxt_state = adc_ctrl_pkg::ST_CONVERT;
            end
         end
         adc_ctrl_pkg::ST_CONVERT: begin
            if (last_end) begin
               nxt_state = adc_ctrl_pkg::ST_IDLE;
            end
         end
         adc_ctrl_pkg::ST_POWER_DOWN: begin
            if (wr_latch && !cw1_hold_pd()) begin
               nxt_state = adc_ctrl_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = adc_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   // power-down bit of the word being latched
   function automatic logic cw1_hold_pd();
      cw1_hold_pd = cw_wr_ff[`CW_PD_BIT];
   endfunction : cw1_hold_pd

   // control word capture while strobes are low
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         cw_wr_ff <= `CW_RESET_VALUE;
         cw_ff <= `CW_RESET_VALUE;
      end else begin
         if (wr_act) begin
            cw_wr_ff <= cw2_ff;
         end
         if (wr_latch && !cw_pd) begin
            cw_ff <= cw_wr_ff;
         end
      end
   end

   // sequencer counters, sample hold, flag
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
         cyc_ff <= '0;
         chan_ff <= '0;
         done_n_ff <= 1'b1;
         hold_ff <= 1'b0;
         held_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == adc_ctrl_pkg::ST_IDLE && nxt_state == adc_ctrl_pkg::ST_CONVERT) begin
            held_ff <= cw_ff[`CW_BANK_BIT] ? i_sample_bank_b : i_sample_bank_a;
            hold_ff <= 1'b1;
            cyc_ff <= '0;
            chan_ff <= '0;
         end else if (conv_end) begin
            cyc_ff <= '0;
            chan_ff <= last_end ? '0 : chan_ff + AW'(1);
         end else if (state_ff == adc_ctrl_pkg::ST_CONVERT) begin
            cyc_ff <= cyc_ff + CW'(1);
         end
         if (last_end) begin
            done_n_ff <= 1'b0;
            hold_ff <= 1'b0;
         end else if (rd_fall && state_ff != adc_ctrl_pkg::ST_POWER_DOWN) begin
            done_n_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // read pointer and bus drive
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rptr_ff <= '0;
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= rd_act;
         if (state_ff == adc_ctrl_pkg::ST_CONVERT && nxt_state != state_ff) begin
            rptr_ff <= '0;
         end else if (rd_rise) begin
            rptr_ff <= (rptr_ff == last_chan) ? '0 : rptr_ff + AW'(1);
         end
      end
   end

   result_memory #(
      .WIDTH(WIDTH),
      .DEPTH(CHANNELS)
   ) u_mem (
      .i_clock(i_clock),
      .i_wr_en(conv_end),
      .i_wr_addr(chan_ff),
      .i_wr_data(cur_sample),
      .i_rd_addr(rptr_ff),
      .o_rd_data(o_result_bus)
   );

   // registered status outputs
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_power_down <= 1'b0;
         o_bank_b <= 1'b0;
         o_channel_count <= 2'h0;
      end else begin
         o_power_down <= (nxt_state == adc_ctrl_pkg::ST_POWER_DOWN);
         o_bank_b <= cw_ff[`CW_BANK_BIT];
         o_channel_count <= cw_ff[`CW_CNT_MSB:`CW_CNT_LSB];
      end
   end

   assign o_done_n = done_n_ff;
   assign o_hold = hold_ff;
   assign o_result_oe = oe_ff;
endmodule : adc_power_mode_control
`default_nettype wire

// ### shared/adc_ctrl_defs.svh
// constant macros for the converter control block
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define CW_PD_BIT 3
`define CW_BANK_BIT 2
`define CW_CNT_LSB 0
`define CW_CNT_MSB 1
`define CW_RESET_VALUE 4'h0
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 3000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### shared/adc_ctrl_pkg.sv
// types for the converter control block
`default_nettype none
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_POWER_DOWN
   } seq_state_e;
   typedef logic [13:0] sample_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ### core/result_memory.sv
// four-word result memory with registered read data
`default_nettype none
module result_memory #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 4
) (
   input wire logic i_clock,
   input wire logic i_wr_en,
   input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
   output logic [WIDTH-1:0] o_rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // no reset: contents undefined until written
   always_ff @(posedge i_clock) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
   end
endmodule : result_memory
`default_nettype wire

// ### test/adc_pmc_chk.sv
// assertions on the ports of the converter control block
`default_nettype none
module adc_pmc_chk #(
   parameter int CONV_CYCLES = 4
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_cs_n,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic i_convert_start_n,
   input wire logic [3:0] i_control_word_bits,
   input wire logic o_result_oe,
   input wire logic o_done_n,
   input wire logic o_power_down,
   input wire logic o_bank_b,
   input wire logic o_hold,
   input wire logic [1:0] o_channel_count
);
   localparam int MAXC = CONV_CYCLES * 4 + 8;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // write strobe rising under chip select while hold is low (idle or power-down)
   sequence wr_rise;
      !i_cs_n && $rose(i_wr_n) && !o_hold;
   endsequence
   property p_wake;
      logic [3:0] w;
      (wr_rise, w = i_control_word_bits) ##0 !w[3] |-> ##[1:8]
         (!o_power_down && o_bank_b == w[2] && o_channel_count == w[1:0]);
   endproperty
   a_reset_state: assert property (
      $rose(i_nrst) |-> o_done_n && !o_power_down && !o_bank_b && o_channel_count == 2'h0)
      else $error("reset state wrong");
   a_pd_enter: assert property (
      wr_rise ##0 i_control_word_bits[3] |-> ##[1:8] o_power_down)
      else $error("power-down not entered");
   a_wake_mode: assert property (p_wake)
      else $error("wake mode wrong");
   a_pd_frozen: assert property (
      o_power_down && $past(o_power_down) |-> $stable(o_done_n))
      else $error("flag moved in power-down");
   a_pd_no_start: assert property ($rose(o_hold) |-> !o_power_down)
      else $error("start taken in power-down");
   a_hold_min: assert property ($rose(o_hold) |-> o_hold[*4])
      else $error("sequence too short");
   a_hold_max: assert property ($rose(o_hold) |-> ##[1:MAXC] !o_hold)
      else $error("sequence too long");
   a_flag_at_end: assert property ($fell(o_hold) |-> ##[0:2] !o_done_n)
      else $error("flag not low at end");
   a_read_clears: assert property ($rose(o_result_oe) |-> ##[0:3] o_done_n)
      else $error("read left flag low");
   // bus drive follows chip select and read after the synchroniser lag
   a_oe_drive: assert property ((!i_cs_n && !i_rd_n) [*4] |-> o_result_oe)
      else $error("bus not driven in read");
   a_oe_release: assert property ((i_cs_n || i_rd_n) [*4] |-> !o_result_oe)
      else $error("bus driven outside read");
endmodule : adc_pmc_chk
`default_nettype wire

// ### test/adc_host_model.sv
// host processor model driving the converter strobes
`default_nettype none
module adc_host_model (
   input wire logic i_clock,
   input wire logic i_done_n,
   input wire logic [13:0] i_result_bus,
   output logic o_cs_n,
   output logic o_wr_n,
   output logic o_rd_n,
   output logic o_convert_start_n,
   output logic [3:0] o_word
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {o_cs_n, o_wr_n, o_rd_n, o_convert_start_n} = 4'hf;
      o_word = 4'hf;
   end
   task automatic step(input int n);
      repeat (n) @(negedge i_clock);
   endtask : step
   // word held past the write rise, then bus shows the inverse
   task automatic write_word(input logic [3:0] w);
      step(1);
      o_cs_n = 1'b0;
      o_word = w;
      step(3);
      o_wr_n = 1'b0;
      step(4);
      o_wr_n = 1'b1;
      step(4);
      o_cs_n = 1'b1;
      o_word = ~w;
      step(6);
   endtask : write_word
   task automatic convert(input bit wait_done);
      step(1);
      o_convert_start_n = 1'b0;
      step(4);
      o_convert_start_n = 1'b1;
      for (int k = 0; k < 400 && wait_done && i_done_n !== 1'b0; k++) step(1);
   endtask : convert
   task automatic read_word(output logic [13:0] d, input bit hold_cs);
      step(3);
      o_cs_n = 1'b0;
      o_rd_n = 1'b0;
      step(6);
      d = i_result_bus;
      o_rd_n = 1'b1;
      step(4);
      o_cs_n = hold_cs ? 1'b0 : 1'b1;
   endtask : read_word
   // four reads under one select, only the chosen one latched
   task automatic demux(input logic [1:0] sel, output logic [13:0] q);
      logic [13:0] d;
      for (int i = 0; i < 4; i++) begin
         read_word(d, i < 3);
         if (i == sel) q = d;
      end
   endtask : demux
endmodule : adc_host_model
`default_nettype wire

// ### test/adc_power_mode_control_test.sv
// self-checking bench for the converter control block
`default_nettype none
module adc_power_mode_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock, i_nrst, cs_n, wr_n, rd_n, cst_n, oe, done_n, pd, bank_sel, hold;
   logic [3:0] word;
   logic [1:0] cnt;
   logic [13:0] result, got;
   logic [55:0] bank_a;
   logic [55:0] bank_b;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   adc_power_mode_control #(.CONV_CYCLES(4)) dut (.i_clock(i_clock), .i_nrst(i_nrst),
      .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_convert_start_n(cst_n),
      .i_control_word_bits(word), .i_sample_bank_a(bank_a), .i_sample_bank_b(bank_b),
      .o_result_bus(result), .o_result_oe(oe), .o_done_n(done_n), .o_power_down(pd),
      .o_bank_b(bank_sel), .o_hold(hold), .o_channel_count(cnt));
   adc_host_model host (.i_clock(i_clock), .i_done_n(done_n), .i_result_bus(result),
      .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_convert_start_n(cst_n), .o_word(word));
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   function automatic logic [13:0] smp(input logic b, input int c);
      return b ? bank_b[c*14 +: 14] : bank_a[c*14 +: 14];
   endfunction : smp
   task automatic cmp(input logic [13:0] g, input logic [13:0] e, input string m);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : cmp
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // cycle ceiling against hangs
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      bank_a = {14'h0001, 14'h3fff, 14'h1fff, 14'h2000};
      bank_b = {14'h2abc, 14'h0123, 14'h3555, 14'h0aaa};
      i_nrst = 1'b0;
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      i_nrst = 1'b1;
      cmp({7'h0, oe, cnt, done_n, pd, bank_sel, hold}, 14'h0008, "reset");
      repeat (100) @(negedge i_clock);
      host.convert(1'b1);
      host.read_word(got, 1'b0);
      cmp(got, smp(1'b0, 0), "default");
      $display("test reset and default done");
      for (int m = 0; m < 8; m++) begin
         host.write_word(m[3:0]);
         cmp({10'h0, pd, bank_sel, cnt}, {11'h0, m[2:0]}, "mode");
         host.convert(1'b1);
         for (int c = 0; c <= m[1:0] + 1; c++) begin
            host.read_word(got, 1'b0);
            cmp(got, smp(m[2], c > m[1:0] ? 0 : c), "read");
         end
      end
      $display("test modes done");
      host.convert(1'b0);
      // new levels only after the first start has taken its samples
      repeat (3) @(negedge i_clock);
      bank_b = ~bank_b;
      host.convert(1'b1);
      for (int c = 0; c < 4; c++) begin
         host.read_word(got, 1'b0);
         cmp(got, ~smp(1'b1, c), "busy start");
      end
      $display("test busy start done");
      host.write_word(4'h8);
      cmp({10'h0, pd, bank_sel, cnt}, 14'h000f, "power-down");
      host.convert(1'b0);
      repeat (30) @(negedge i_clock);
      cmp({12'h0, done_n, hold}, 14'h0002, "pd start");
      // fresh bank a levels must be taken by the first start after wake
      bank_a = ~bank_a;
      host.write_word(4'h3);
      cmp({10'h0, pd, bank_sel, cnt}, 14'h0003, "wake");
      repeat (100) @(negedge i_clock);
      host.convert(1'b1);
      host.demux(2'h2, got);
      cmp(got, smp(1'b0, 2), "demux");
      $display("test power-down done");
      complete_run();
   end
endmodule : adc_power_mode_control_test
bind adc_power_mode_control adc_pmc_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
   .i_clock(i_clock), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n), .i_rd_n(i_rd_n),
   .i_convert_start_n(i_convert_start_n), .i_control_word_bits(i_control_word_bits),
   .o_result_oe(o_result_oe), .o_done_n(o_done_n), .o_power_down(o_power_down),
   .o_bank_b(o_bank_b), .o_hold(o_hold), .o_channel_count(o_channel_count));
`default_nettype wire
